// *** common/ufc_pkg.sv ***
/*
 Shared constants and carrier types of the UART flow-control block.
 Assumes byte-wide registers, each on one aligned APB word.
*/
package ufc_pkg;
    localparam int FILL_W = 5;
    localparam int EV_W = 5;
    // Byte addresses of the register words
    localparam logic [7:0] A_IER = 8'h00;
    localparam logic [7:0] A_FCR = 8'h04;
    localparam logic [7:0] A_ISR = 8'h08;
    localparam logic [7:0] A_LCR = 8'h0C;
    localparam logic [7:0] A_MCR = 8'h10;
    localparam logic [7:0] A_LSR = 8'h14;
    localparam logic [7:0] A_MSR = 8'h18;
    localparam logic [7:0] A_SPR = 8'h1C;
    localparam logic [7:0] A_ENHANCED_MODE_SELECT = 8'h20;
    localparam logic [7:0] A_FEATURE_CONTROL_REG = 8'h24;
    localparam logic [7:0] A_EFR = 8'h28;
    localparam logic [7:0] A_RESUME_CHAR_ONE = 8'h2C;
    localparam logic [7:0] A_RESUME_CHAR_TWO = 8'h30;
    localparam logic [7:0] A_PAUSE_CHAR_ONE = 8'h34;
    localparam logic [7:0] A_PAUSE_CHAR_TWO = 8'h38;
    localparam logic [7:0] A_DLL = 8'h3C;
    localparam logic [7:0] A_DLM = 8'h40;
    localparam logic [7:0] A_DLD = 8'h44;
    localparam logic [7:0] A_EVT = 8'h48;
    localparam logic [7:0] A_MASK = 8'h4C;
    // Reset values
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_ISR = 8'h01;
    localparam logic [7:0] RST_LSR = 8'h60;
    localparam logic [7:0] RST_SPR = 8'hFF;
    localparam logic [7:0] RST_DLL = 8'h01;
    localparam logic [7:0] RST_DLM = 8'h00;
    localparam logic [3:0] RST_NIB = 4'h0;
    // Field positions
    localparam int EFR_AUTO_RTS = 6;
    localparam int EFR_AUTO_CTS = 7;
    localparam int MCR_DTR = 0;
    localparam int MCR_RTS = 1;
    localparam int MCR_OUT2 = 3;
    localparam int ENHANCED_MODE_SELECT_MDROP = 0;
    localparam int EV_RXTRIG = 0;
    localparam int EV_RTS = 1;
    localparam int EV_CTS = 2;
    localparam int EV_ADDR = 3;
    localparam int EV_MODEM = 4;

    typedef struct packed {
        logic bus16;
        logic pwr_save;
        logic cd_n;
        logic ri_n;
        logic dsr_n;
        logic cts_n;
    } ufc_pins_t;

    typedef struct packed {
        logic stop;
    } ufc_rts_st_t;

    typedef struct packed {
        logic [7:0] dll;
        logic [7:0] divisor_high_byte;
    } ufc_div_t;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic [7:0] interrupt_enable_reg, fifo_control_reg, interrupt_status, line_control_reg, modem_control_reg, line_status_reg, scratchpad_reg, enhanced_mode_select, feature_control_reg, enhanced_feature_control, divisor_fraction;
        logic [7:0] resume_char_one, resume_char_two, pause_char_one, pause_char_two;
        logic [3:0] msr_lo, msr_wr, modem_q;
        logic [EV_W-1:0] evt, mask;
        logic trig_q, stop_q, pause_q;
        logic rts_n, dtr_n, tx_out, tx_pause, addr_match, intr, intr_oe, irq_n;
    } ufc_state_t;
endpackage : ufc_pkg

// *** rtl/ufc_sync.sv ***
/*
 Two-flop synchroniser for a group of pin levels.
 Assumes the inputs are asynchronous levels; first stage feeds only the second.
*/
`timescale 1ns/1ns
module ufc_sync #(
    parameter int W = 6
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= '1;
            q <= '1;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule : ufc_sync

// *** rtl/ufc_rts_ctl.sv ***
/*
 Hysteresis tracker of the receive FIFO fill for automatic request-to-send.
 Assumes fill and thresholds come from logic on the same clock, lower <= upper.
*/
`timescale 1ns/1ns
module ufc_rts_ctl
    import ufc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic auto_en,
    input wire logic sw_assert,
    input wire logic [FILL_W-1:0] fill,
    input wire logic [FILL_W-1:0] upper,
    input wire logic [FILL_W-1:0] lower,
    output logic next_rts_n,
    output logic next_stop
);
    ufc_rts_st_t s;
    ufc_rts_st_t next_s;

    always_comb begin
        next_s = s;
        if (fill >= upper) begin
            next_s.stop = 1'b1;
        end else if (fill < lower) begin
            next_s.stop = 1'b0;
        end
        next_stop = auto_en & next_s.stop;
        // Pin stays high until software asserts it; auto mode only adds a stop
        next_rts_n = ~sw_assert | next_stop;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end
endmodule : ufc_rts_ctl

// *** rtl/ufc_top.sv ***
/*
 Flow-control, reset and register block of an enhanced UART, APB slave.
 Assumes receive fill, thresholds and received characters come from
 logic on pclk; modem, power-save and bus-mode pins are asynchronous.
*/
// The register addresses and the APB slave port were chosen for this implementation.
`timescale 1ns/1ns
// Notes on behaviour
// - Auto request-to-send is off after reset and on only while feature bit 6 is one.
// - With auto request-to-send on, reaching the receive trigger raises an interrupt.
// - With auto request-to-send on, reaching the upper level drives the pin high.
// - The pin returns low once the fill drops below the lower level.
// - Without hardware flow control the pin follows its software bit only.
// - Auto clear-to-send is off after reset and on only while feature bit 7 is set.
// - With auto clear-to-send on, transmission pauses while the input is one.
// - Four read-write byte registers hold two resume and two pause characters.
// - In multidrop mode the second pause character is the station address.
// - Divisor bytes take 0x00 and 0x01 only at power-up, not at pin reset.
// - Reset clears the modem status low nibble and its writable upper nibble.
// - In power-save the bus address, data and strobes are ignored.
module ufc_top
    import ufc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic por_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic pslverr,
    output logic [31:0] prdata,
    input wire logic cts_n,
    input wire logic dsr_n,
    input wire logic ri_n,
    input wire logic cd_n,
    input wire logic pwr_save,
    input wire logic bus_mode16,
    input wire logic [FILL_W-1:0] rx_fill,
    input wire logic [FILL_W-1:0] rx_trig,
    input wire logic [FILL_W-1:0] rts_upper,
    input wire logic [FILL_W-1:0] rts_lower,
    input wire logic rx_char_valid,
    input wire logic rx_char_addr,
    input wire logic [7:0] rx_char,
    input wire logic tx_serial,
    input wire logic tx_empty,
    output logic tx_out,
    output logic tx_pause,
    output logic rts_n,
    output logic dtr_n,
    output logic addr_match,
    output logic intr,
    output logic intr_oe,
    output logic irq_n,
    output logic [15:0] divisor
);
    ufc_state_t s;
    ufc_state_t next_s;
    ufc_div_t dv;
    ufc_div_t next_dv;
    ufc_pins_t pin_s;
    logic next_rts_n;
    logic next_stop;
    logic sel_on;
    logic setup;
    logic done;
    logic [3:0] modem_now;
    logic [EV_W-1:0] ev_in;
    logic [7:0] rdv;
    logic hit;

    ufc_sync #(.W(6)) u_sync (
        .clk(pclk),
        .rst_n(presetn),
        // Power-save travels inverted so the reset value of the chain reads as awake
        .d({bus_mode16, ~pwr_save, cd_n, ri_n, dsr_n, cts_n}),
        .q(pin_s)
    );

    ufc_rts_ctl u_rts (
        .clk(pclk),
        .rst_n(presetn),
        .auto_en(s.enhanced_feature_control[EFR_AUTO_RTS]),
        .sw_assert(s.modem_control_reg[MCR_RTS]),
        .fill(rx_fill),
        .upper(rts_upper),
        .lower(rts_lower),
        .next_rts_n(next_rts_n),
        .next_stop(next_stop)
    );

    // Bus strobes are gated off while power-save holds
    assign sel_on = psel & pin_s.pwr_save;
    assign setup = sel_on & ~penable;
    assign done = sel_on & penable & s.pready;
    // Active-high modem levels: carrier, ring, data-set-ready, clear-to-send
    assign modem_now = ~{pin_s.cd_n, pin_s.ri_n, pin_s.dsr_n, pin_s.cts_n};

    always_comb begin
        hit = 1'b1;
        unique case (paddr)
            A_IER: rdv = s.interrupt_enable_reg;
            A_FCR: rdv = s.fifo_control_reg;
            A_ISR: rdv = s.interrupt_status;
            A_LCR: rdv = s.line_control_reg;
            A_MCR: rdv = s.modem_control_reg;
            A_LSR: rdv = s.line_status_reg;
            A_MSR: rdv = {modem_now, s.msr_lo};
            A_SPR: rdv = s.scratchpad_reg;
            A_ENHANCED_MODE_SELECT: rdv = s.enhanced_mode_select;
            A_FEATURE_CONTROL_REG: rdv = s.feature_control_reg;
            A_EFR: rdv = s.enhanced_feature_control;
            A_RESUME_CHAR_ONE: rdv = s.resume_char_one;
            A_RESUME_CHAR_TWO: rdv = s.resume_char_two;
            A_PAUSE_CHAR_ONE: rdv = s.pause_char_one;
            A_PAUSE_CHAR_TWO: rdv = s.pause_char_two;
            A_DLL: rdv = dv.dll;
            A_DLM: rdv = dv.divisor_high_byte;
            A_DLD: rdv = s.divisor_fraction;
            A_EVT: rdv = {3'h0, s.evt};
            A_MASK: rdv = {3'h0, s.mask};
            default: begin
                rdv = 8'h00;
                hit = 1'b0;
            end
        endcase
    end

    always_comb begin
        next_s = s;
        next_dv = dv;
        ev_in = '0;

        // APB: answer in the access cycle that follows each setup
        next_s.pready = setup;
        if (setup) begin
            next_s.prdata = {24'h00_0000, rdv};
            next_s.pslverr = ~hit;
        end else if (done) begin
            next_s.prdata = 32'h0000_0000;
            next_s.pslverr = 1'b0;
        end

        if (done && pwrite && !s.pslverr) begin
            unique case (paddr)
                A_IER: next_s.interrupt_enable_reg = pwdata[7:0];
                A_FCR: next_s.fifo_control_reg = pwdata[7:0];
                A_LCR: next_s.line_control_reg = pwdata[7:0];
                A_MCR: next_s.modem_control_reg = pwdata[7:0];
                A_MSR: next_s.msr_wr = pwdata[7:4];
                A_SPR: next_s.scratchpad_reg = pwdata[7:0];
                A_ENHANCED_MODE_SELECT: next_s.enhanced_mode_select = pwdata[7:0];
                A_FEATURE_CONTROL_REG: next_s.feature_control_reg = pwdata[7:0];
                A_EFR: next_s.enhanced_feature_control = pwdata[7:0];
                A_RESUME_CHAR_ONE: next_s.resume_char_one = pwdata[7:0];
                A_RESUME_CHAR_TWO: next_s.resume_char_two = pwdata[7:0];
                A_PAUSE_CHAR_ONE: next_s.pause_char_one = pwdata[7:0];
                A_PAUSE_CHAR_TWO: next_s.pause_char_two = pwdata[7:0];
                A_DLL: next_dv.dll = pwdata[7:0];
                A_DLM: next_dv.divisor_high_byte = pwdata[7:0];
                A_DLD: next_s.divisor_fraction = pwdata[7:0];
                A_MASK: next_s.mask = pwdata[EV_W-1:0];
                default: next_s.interrupt_status = s.interrupt_status;
            endcase
        end

        // Modem deltas: ring counts its trailing edge
        next_s.modem_q = modem_now;
        if (done && !pwrite && paddr == A_MSR) begin
            next_s.msr_lo = s.prdata[3:0] ^ s.msr_lo;
        end
        next_s.msr_lo[0] = next_s.msr_lo[0] | (modem_now[0] ^ s.modem_q[0]);
        next_s.msr_lo[1] = next_s.msr_lo[1] | (modem_now[1] ^ s.modem_q[1]);
        next_s.msr_lo[2] = next_s.msr_lo[2] | (s.modem_q[2] & ~modem_now[2]);
        next_s.msr_lo[3] = next_s.msr_lo[3] | (modem_now[3] ^ s.modem_q[3]);

        // Receive trigger event under auto request-to-send
        next_s.trig_q = s.enhanced_feature_control[EFR_AUTO_RTS] & (rx_fill >= rx_trig);
        ev_in[EV_RXTRIG] = next_s.trig_q & ~s.trig_q;
        next_s.rts_n = next_rts_n;
        next_s.stop_q = next_stop;
        ev_in[EV_RTS] = next_stop & ~s.stop_q;

        // Transmit pause while clear-to-send is inactive
        next_s.tx_pause = s.enhanced_feature_control[EFR_AUTO_CTS] & pin_s.cts_n;
        next_s.pause_q = next_s.tx_pause;
        ev_in[EV_CTS] = next_s.tx_pause & ~s.pause_q;

        // Station address compare in multidrop mode
        next_s.addr_match = s.enhanced_mode_select[ENHANCED_MODE_SELECT_MDROP] & rx_char_valid & rx_char_addr
            & (rx_char == s.pause_char_two);
        ev_in[EV_ADDR] = next_s.addr_match;
        ev_in[EV_MODEM] = |(modem_now ^ s.modem_q);

        // Sticky events: read clears the returned bits, a new event wins
        if (done && !pwrite && paddr == A_EVT) begin
            next_s.evt = s.evt & ~s.prdata[EV_W-1:0];
        end
        next_s.evt = next_s.evt | ev_in;

        next_s.interrupt_status = {7'h00, ~|(s.evt & s.mask)};
        next_s.line_status_reg = {1'b0, tx_empty, tx_empty, 4'h0, |rx_fill};
        next_s.dtr_n = ~s.modem_control_reg[MCR_DTR];
        next_s.tx_out = tx_serial;
        next_s.intr = |(next_s.evt & next_s.mask);
        next_s.intr_oe = pin_s.bus16 & s.modem_control_reg[MCR_OUT2];
        next_s.irq_n = pin_s.bus16 | ~next_s.intr;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '{
                pready: 1'b0, pslverr: 1'b0, prdata: 32'h0000_0000,
                interrupt_enable_reg: RST_ZERO, fifo_control_reg: RST_ZERO, interrupt_status: RST_ISR, line_control_reg: RST_ZERO,
                modem_control_reg: RST_ZERO, line_status_reg: RST_LSR, scratchpad_reg: RST_SPR, enhanced_mode_select: RST_ZERO,
                feature_control_reg: RST_ZERO, enhanced_feature_control: RST_ZERO, divisor_fraction: RST_ZERO, resume_char_one: RST_ZERO,
                resume_char_two: RST_ZERO, pause_char_one: RST_ZERO, pause_char_two: RST_ZERO,
                msr_lo: RST_NIB, msr_wr: RST_NIB, modem_q: RST_NIB,
                evt: '0, mask: '0, trig_q: 1'b0, stop_q: 1'b0, pause_q: 1'b0,
                rts_n: 1'b1, dtr_n: 1'b1, tx_out: 1'b1, tx_pause: 1'b0,
                addr_match: 1'b0, intr: 1'b0, intr_oe: 1'b0, irq_n: 1'b1
            };
        end else begin
            s <= next_s;
        end
    end

    // Divisor bytes survive the reset pin, only power-up loads them
    always_ff @(posedge pclk or negedge por_n) begin
        if (!por_n) begin
            dv <= '{dll: RST_DLL, divisor_high_byte: RST_DLM};
        end else begin
            dv <= next_dv;
        end
    end

    assign pready = s.pready;
    assign pslverr = s.pslverr;
    assign prdata = s.prdata;
    assign tx_out = s.tx_out;
    assign tx_pause = s.tx_pause;
    assign rts_n = s.rts_n;
    assign dtr_n = s.dtr_n;
    assign addr_match = s.addr_match;
    assign intr = s.intr;
    assign intr_oe = s.intr_oe;
    assign irq_n = s.irq_n;
    assign divisor = {dv.divisor_high_byte, dv.dll};

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_rts_manual: assert property (
        !s.enhanced_feature_control[EFR_AUTO_RTS] |=> rts_n == !$past(s.modem_control_reg[MCR_RTS]))
        else $error("rts pin does not follow software bit");
    a_rts_stop_hi: assert property (
        s.enhanced_feature_control[EFR_AUTO_RTS] && rx_fill >= rts_upper |=> rts_n)
        else $error("rts not deasserted at upper level");
    a_rts_resume_lo: assert property (
        s.enhanced_feature_control[EFR_AUTO_RTS] && s.modem_control_reg[MCR_RTS] && rx_fill < rts_lower
            && rx_fill < rts_upper |=> !rts_n)
        else $error("rts not reasserted below lower level");
    a_rx_trig_event: assert property (
        s.enhanced_feature_control[EFR_AUTO_RTS] && rx_fill >= rx_trig && !s.trig_q
            |=> s.evt[EV_RXTRIG] ##1 (intr == $past(s.mask[EV_RXTRIG], 2) || !s.mask[EV_RXTRIG]))
        else $error("receive trigger event missing");
    a_cts_pause_on: assert property (
        s.enhanced_feature_control[EFR_AUTO_CTS] && pin_s.cts_n |=> tx_pause)
        else $error("transmit not paused on inactive cts");
    a_cts_auto_off: assert property (
        !s.enhanced_feature_control[EFR_AUTO_CTS] |=> !tx_pause)
        else $error("pause without auto cts enabled");
    a_station_match: assert property (
        s.enhanced_mode_select[ENHANCED_MODE_SELECT_MDROP] && rx_char_valid && rx_char_addr && rx_char == s.pause_char_two
            |=> addr_match ##1 s.evt[EV_ADDR])
        else $error("station address match missed");
    a_bus_isolated: assert property (
        !pin_s.pwr_save && $stable(pin_s.pwr_save) |=> !pready && $stable(s.enhanced_feature_control))
        else $error("bus access taken during power-save");
    a_resume_write: assert property (
        done && pwrite && paddr == A_RESUME_CHAR_ONE |=> s.resume_char_one == $past(pwdata[7:0]))
        else $error("resume character write lost");
endmodule : ufc_top

// *** bench/ufc_remote.sv ***
/*
 Remote serial device on the modem handshake lines.
 Assumes the bench commands when it holds off the transmitter and when it
 signals data-set-ready; all lines change just after a rising pclk edge.
*/
`timescale 1ns/1ns
module ufc_remote (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pause_cmd,
    input wire logic ready_cmd,
    input wire logic rts_n,
    output logic cts_n,
    output logic dsr_n,
    output logic ri_n,
    output logic cd_n
);
    // Holds off the transmitter while commanded; a real peer also drops
    // its own flow on our request line, seen here only as an input
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cts_n <= 1'b1;
            dsr_n <= 1'b1;
        end else begin
            cts_n <= pause_cmd;
            dsr_n <= ~ready_cmd;
        end
    end
    assign ri_n = 1'b1;
    assign cd_n = 1'b1;
endmodule : ufc_remote

// *** bench/ufc_top_tb.sv ***
/*
 Self-checking bench of the flow-control and register block.
 Assumes the APB slave answers in the cycle after setup.
*/
`timescale 1ns/1ns
module ufc_top_tb;
    import ufc_pkg::*;
    logic pclk, presetn, por_n, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic cts_n, dsr_n, ri_n, cd_n, pwr_save, bus_mode16, pause_cmd, ready_cmd;
    logic [FILL_W-1:0] rx_fill, rx_trig, rts_upper, rts_lower;
    logic rx_char_valid, rx_char_addr, tx_serial, tx_empty, e;
    logic [7:0] rx_char;
    logic tx_out, tx_pause, rts_n, dtr_n, addr_match, intr, intr_oe, irq_n;
    logic [15:0] divisor;
    int n_fail = 0;
    int n_compared = 0;
    int hits;
    logic [7:0] ra [18] = '{A_IER, A_FCR, A_ISR, A_LCR, A_MCR, A_LSR, A_MSR, A_SPR,
        A_ENHANCED_MODE_SELECT, A_FEATURE_CONTROL_REG, A_EFR, A_RESUME_CHAR_ONE, A_RESUME_CHAR_TWO, A_PAUSE_CHAR_ONE, A_PAUSE_CHAR_TWO, A_DLL, A_DLM, A_DLD};
    logic [7:0] rv [18] = '{8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h60, 8'h11, 8'hFF,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00};

    ufc_top u_ufc_top (.pclk(pclk), .presetn(presetn), .por_n(por_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .pslverr(pslverr), .prdata(prdata), .cts_n(cts_n),
        .dsr_n(dsr_n), .ri_n(ri_n), .cd_n(cd_n), .pwr_save(pwr_save),
        .bus_mode16(bus_mode16), .rx_fill(rx_fill), .rx_trig(rx_trig),
        .rts_upper(rts_upper), .rts_lower(rts_lower), .rx_char_valid(rx_char_valid),
        .rx_char_addr(rx_char_addr), .rx_char(rx_char), .tx_serial(tx_serial),
        .tx_empty(tx_empty), .tx_out(tx_out), .tx_pause(tx_pause), .rts_n(rts_n),
        .dtr_n(dtr_n), .addr_match(addr_match), .intr(intr), .intr_oe(intr_oe),
        .irq_n(irq_n), .divisor(divisor));
    ufc_remote u_ufc_remote (.pclk(pclk), .presetn(presetn), .pause_cmd(pause_cmd),
        .ready_cmd(ready_cmd), .rts_n(rts_n), .cts_n(cts_n), .dsr_n(dsr_n),
        .ri_n(ri_n), .cd_n(cd_n));

    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    task chk(input logic [31:0] s, input logic [31:0] x);
        n_compared++;
        if (s !== x) begin
            n_fail++;
            $display("[ERR] %0t seen %h exp %h", $time, s, x);
        end
    endtask : chk

    task tick(input int n);
        repeat (n) @(posedge pclk);
        @(negedge pclk);
    endtask : tick

    // One APB transfer; pready and the answer are taken at the completing edge
    task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h00_0000, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 40);
        if (n >= 40) n_fail++;
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task stop_test;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : stop_test

    initial begin
        repeat (3000) @(posedge pclk);
        n_fail++;
        stop_test;
    end

    initial begin
        {presetn, por_n, psel, penable, pwrite, paddr, pwdata} = '0;
        {pwr_save, bus_mode16, pause_cmd, ready_cmd, rx_char_valid, rx_char_addr} = '0;
        {rx_char, tx_serial} = '0;
        tx_empty = 1'b1;
        rx_fill = 5'd0;
        rx_trig = 5'd6;
        rts_upper = 5'd8;
        rts_lower = 5'd4;
        tick(2);
        chk({tx_out, rts_n, dtr_n, irq_n, intr_oe, intr}, 6'b111100);
        @(posedge pclk);
        presetn <= 1'b1;
        por_n <= 1'b1;
        tx_serial <= 1'b1;
        tick(4);
        for (int i = 0; i < 18; i++) begin
            apb(1'b0, ra[i], 8'h00);
            chk(q, {24'h00_0000, rv[i]});
        end
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, ra[11 + i], 8'hA5 ^ 8'(i * 17));
            apb(1'b0, ra[11 + i], 8'h00);
            chk(q, {24'h00_0000, 8'hA5 ^ 8'(i * 17)});
        end
        apb(1'b0, 8'hFC, 8'h00);
        chk(e, 1'b1);
        chk(q, 32'h0000_0000);
        rx_fill <= 5'd16;
        apb(1'b1, A_MCR, 8'h02);
        tick(3);
        chk(rts_n, 1'b0);
        apb(1'b1, A_MASK, 8'h01);
        apb(1'b1, A_EFR, 8'h40);
        tick(3);
        chk(rts_n, 1'b1);
        chk({intr, irq_n}, 2'b10);
        rx_fill <= 5'd5;
        tick(3);
        chk(rts_n, 1'b1);
        rx_fill <= 5'd3;
        tick(3);
        chk(rts_n, 1'b0);
        apb(1'b0, A_EVT, 8'h00);
        chk(q[EV_RXTRIG], 1'b1);
        tick(2);
        chk(intr, 1'b0);
        pause_cmd <= 1'b1;
        apb(1'b1, A_EFR, 8'h00);
        tick(5);
        chk(tx_pause, 1'b0);
        apb(1'b1, A_EFR, 8'h80);
        tick(4);
        chk(tx_pause, 1'b1);
        pause_cmd <= 1'b0;
        tick(5);
        chk(tx_pause, 1'b0);
        apb(1'b0, A_EVT, 8'h00);
        apb(1'b1, A_MASK, 8'h10);
        ready_cmd <= 1'b1;
        tick(5);
        chk(intr, 1'b1);
        apb(1'b0, A_MSR, 8'h00);
        chk(q[7:4], 4'b0011);
        apb(1'b0, A_EVT, 8'h00);
        tick(2);
        chk(intr, 1'b0);
        apb(1'b1, A_ENHANCED_MODE_SELECT, 8'h01);
        apb(1'b1, A_PAUSE_CHAR_TWO, 8'h5A);
        for (int k = 0; k < 2; k++) begin
            @(posedge pclk);
            rx_char_valid <= 1'b1;
            rx_char_addr <= 1'b1;
            rx_char <= k ? 8'h33 : 8'h5A;
            @(posedge pclk);
            rx_char_valid <= 1'b0;
            hits = 0;
            repeat (4) begin
                @(negedge pclk);
                hits += int'(addr_match === 1'b1);
            end
            chk(hits, k ? 0 : 1);
        end
        pwr_save <= 1'b1;
        tick(3);
        psel <= 1'b1;
        pwrite <= 1'b1;
        paddr <= A_SPR;
        pwdata <= 32'h0000_0012;
        @(posedge pclk);
        penable <= 1'b1;
        hits = 0;
        repeat (4) begin
            @(negedge pclk);
            hits += int'(pready === 1'b1);
        end
        chk(hits, 0);
        @(posedge pclk);
        {psel, penable, pwr_save} <= '0;
        tick(3);
        apb(1'b0, A_SPR, 8'h00);
        chk(q, 32'h0000_00FF);
        apb(1'b1, A_DLL, 8'h55);
        @(posedge pclk);
        presetn <= 1'b0;
        tick(2);
        chk(divisor, 16'h0055);
        @(posedge pclk);
        presetn <= 1'b1;
        tick(3);
        apb(1'b0, A_RESUME_CHAR_ONE, 8'h00);
        chk(q, 32'h0000_0000);
        bus_mode16 <= 1'b1;
        apb(1'b1, A_MCR, 8'h08);
        tick(4);
        chk({intr_oe, irq_n}, 2'b11);
        tx_serial <= 1'b0;
        tick(2);
        chk(tx_out, 1'b0);
        stop_test;
    end
endmodule : ufc_top_tb
